/* rtl/dac_log_slew_and_common_config.sv */
// Register bank for per-channel log-slew waveform settings, code words and shared settings.
// Assumes a decoded serial register port on clk; bound codes come from same-clock logic.
// What this block does
// (R1) Slew-type bit set: ramp between bound codes, either direction, 3.125 percent steps.
// (R2) Rising: next step is present step times one plus 1/32.
// (R3) Falling: next step is present step times one minus 1/32.
// (R4) Lower bound zero: ramp starts at code one.
// (R5) Rise interval field bits 6-4 picks 4 to 5127.92 us per step.
// (R6) Fall interval field bits 3-1 uses the same eight intervals.
// (R7) Wave select: triangle, sawtooth, inverse sawtooth, sine, off; others invalid.
// (R8) Code word holds left-aligned straight binary in bits 15-4.
// (R9) Code word resets to zero; bits 3-0 ignored on write.
// (R10) Shared bit 15 selects latching window-comparator output.
// (R11) Lock bit 14 blocks register writes until unlocked.
// (R12) Host writes unlock key first, then writes lock bit zero.
// (R13) Shared bit 13 selects fault-log row 0x00 or 0x01.
// (R14) Host sets reference enable before internal-reference gains; off at reset.
// (R15) Two-bit voltage power field per channel; current power-down bit per channel.
// (R16) Shared word resets to 0fff: outputs powered down, bits 15-12 clear.
// (R17) Unlock key is pattern 0101.
// (R18) Per-channel run bit starts generation when one, stops when zero.
// (R19) Steps timed by internal counter; output stops at bound without overshoot.
// (R20) Invalid wave code stored but no generation; output holds.
// (R21) Locked writes other than key and lock bit are ignored.
`include "dac_slew_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dac_log_slew_and_common_config #(
    parameter int unsigned RES_BITS  = 12,
    parameter int unsigned STEP_CYC [8] = '{`STEP_NS_0 / `CLK_NS, `STEP_NS_1 / `CLK_NS,
                                            `STEP_NS_2 / `CLK_NS, `STEP_NS_3 / `CLK_NS,
                                            `STEP_NS_4 / `CLK_NS, `STEP_NS_5 / `CLK_NS,
                                            `STEP_NS_6 / `CLK_NS, `STEP_NS_7 / `CLK_NS}
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [11:0] bound_low_first,
    input  wire logic [11:0] bound_high_first,
    input  wire logic [11:0] bound_low_second,
    input  wire logic [11:0] bound_high_second,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic      [11:0] out_code_first,
    output logic      [11:0] out_code_second,
    output logic             busy_first,
    output logic             busy_second,
    output logic             window_hold_select,
    output logic             fault_log_row_select,
    output logic             int_ref_enable,
    output logic      [1:0]  volt_out_shutdown_first,
    output logic      [1:0]  volt_out_shutdown_second,
    output logic             curr_out_shutdown_first,
    output logic             curr_out_shutdown_second
);
    // Channel 0 is the first (0x19 / 0x06), channel 1 the second (0x1c / 0x18)
    localparam logic [11:0] RES_MASK = 12'(((1 << RES_BITS) - 1) << (12 - RES_BITS));

    dac_slew_pkg::state_t st_r;
    dac_slew_pkg::state_t st_nxt;
    logic [11:0]          lo_in [2];
    logic [11:0]          hi_in [2];

    assign lo_in[0] = bound_low_first;
    assign lo_in[1] = bound_low_second;
    assign hi_in[0] = bound_high_first;
    assign hi_in[1] = bound_high_second;

    // Interval decode, shared by rise and fall fields
    function automatic logic [19:0] step_interval(input logic [2:0] sel);
        step_interval = 20'(STEP_CYC[sel]); // R5 R6
    endfunction : step_interval

    function automatic logic wave_valid(input logic [2:0] w);
        wave_valid = (w == `WAVE_TRIANGLE) || (w == `WAVE_SAW) ||
                     (w == `WAVE_INV_SAW) || (w == `WAVE_SINE); // R7
    endfunction : wave_valid

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: register writes, readback, ramp engines
    always_comb begin
        logic        locked;
        logic [2:0]  wave;
        logic [20:0] lo_fx;
        logic [20:0] hi_fx;
        logic [20:0] down_step;
        logic [21:0] sum;
        logic [19:0] ivl;
        locked    = st_r.shared[`F_WRITE_LOCK];
        wave      = 3'h0;
        lo_fx     = '0;
        hi_fx     = '0;
        down_step = '0;
        sum       = '0;
        ivl       = '0;
        st_nxt    = st_r;
        st_nxt.rvalid = rd_en;
        st_nxt.rdata  = 16'h0000;
        // Readback; unmapped indices read zero
        if (rd_en) begin
            case (reg_addr)
                `ADDR_WAVE_SET_FIRST:   st_nxt.rdata = st_r.ch[0].wave_set;
                `ADDR_WAVE_SET_SECOND:  st_nxt.rdata = st_r.ch[1].wave_set;
                `ADDR_CODE_WORD_FIRST:  st_nxt.rdata = st_r.ch[0].code_word;
                `ADDR_CODE_WORD_SECOND: st_nxt.rdata = st_r.ch[1].code_word;
                `ADDR_SHARED_SETTINGS:  st_nxt.rdata = st_r.shared;
                `ADDR_SHARED_ACTION:    st_nxt.rdata = {st_r.key, 12'h000};
                `ADDR_SHARED_RUN:       st_nxt.rdata = {3'h0, st_r.run[0], 11'h000, st_r.run[1]}; // R18
                default:                st_nxt.rdata = 16'h0000;
            endcase
        end
        // Writes; while locked only the key field and the lock bit get through
        if (wr_en) begin
            case (reg_addr)
                `ADDR_SHARED_ACTION: st_nxt.key = wr_data[`F_KEY_HI:`F_KEY_LO];
                `ADDR_SHARED_SETTINGS: begin
                    if (!locked) begin
                        st_nxt.shared = wr_data; // R10 R13 R15
                    end else if (!wr_data[`F_WRITE_LOCK] && st_r.key == `UNLOCK_KEY) begin
                        st_nxt.shared[`F_WRITE_LOCK] = 1'b0; // R11 R12 R17
                    end
                end
                `ADDR_SHARED_RUN: begin
                    if (!locked) begin // R21
                        st_nxt.run[0] = wr_data[`F_RUN_FIRST];
                        st_nxt.run[1] = wr_data[`F_RUN_SECOND];
                    end
                end
                `ADDR_WAVE_SET_FIRST:   if (!locked) st_nxt.ch[0].wave_set = wr_data; // R21
                `ADDR_WAVE_SET_SECOND:  if (!locked) st_nxt.ch[1].wave_set = wr_data; // R21
                `ADDR_CODE_WORD_FIRST:  if (!locked) begin
                    st_nxt.ch[0].code_word = {wr_data[`F_CODE_HI:`F_CODE_LO] & RES_MASK, `CODE_IGNORED}; // R8 R9
                end
                `ADDR_CODE_WORD_SECOND: if (!locked) begin
                    st_nxt.ch[1].code_word = {wr_data[`F_CODE_HI:`F_CODE_LO] & RES_MASK, `CODE_IGNORED}; // R8 R9
                end
                default: ;
            endcase
        end
        // Ramp engines, one per channel
        for (int i = 0; i < 2; i++) begin
            wave      = st_r.ch[i].wave_set[`F_WAVE_HI:`F_WAVE_LO];
            lo_fx     = {1'b0, (lo_in[i] == 12'h000) ? 12'h001 : lo_in[i], 8'h00}; // R4
            hi_fx     = {1'b0, hi_in[i], 8'h00};
            down_step = (hi_fx >> `GROW_SHIFT) < `FRAC_ONE ? `FRAC_ONE : hi_fx >> `GROW_SHIFT;
            sum       = 22'(st_r.ch[i].pos) + 22'(st_r.ch[i].step);
            ivl       = (st_r.ch[i].ph == dac_slew_pkg::PH_DOWN)
                        ? step_interval(st_r.ch[i].wave_set[`F_FALL_HI:`F_FALL_LO])
                        : step_interval(st_r.ch[i].wave_set[`F_RISE_HI:`F_RISE_LO]);
            if (!st_r.run[i]) begin
                // Stopped: output follows the code word
                st_nxt.ch[i].ph    = dac_slew_pkg::PH_IDLE; // R18
                st_nxt.ch[i].out   = st_r.ch[i].code_word[`F_CODE_HI:`F_CODE_LO];
                st_nxt.ch[i].timer = '0;
            end else if (!wave_valid(wave) || !st_r.ch[i].wave_set[`F_LOG_SLEW]) begin
                // Invalid, off or linear mode: hold the present code
                st_nxt.ch[i].ph = dac_slew_pkg::PH_IDLE; // R20
            end else if (st_r.ch[i].ph == dac_slew_pkg::PH_IDLE) begin
                st_nxt.ch[i].timer = '0; // R18
                if (wave == `WAVE_INV_SAW) begin
                    st_nxt.ch[i].ph   = dac_slew_pkg::PH_DOWN;
                    st_nxt.ch[i].pos  = hi_fx;
                    st_nxt.ch[i].step = down_step;
                end else begin
                    st_nxt.ch[i].ph   = dac_slew_pkg::PH_UP;
                    st_nxt.ch[i].pos  = lo_fx; // R4
                    st_nxt.ch[i].step = `FRAC_ONE;
                end
            end else if (st_r.ch[i].timer < ivl - 20'h00001) begin
                st_nxt.ch[i].timer = st_r.ch[i].timer + 20'h00001; // R19
            end else begin
                st_nxt.ch[i].timer = '0;
                if (st_r.ch[i].ph == dac_slew_pkg::PH_UP) begin
                    if (sum >= 22'(hi_fx)) begin
                        // Clamp at the upper bound, never past it
                        st_nxt.ch[i].pos = hi_fx; // R19
                        if (wave == `WAVE_SAW) begin
                            st_nxt.ch[i].pos  = lo_fx;
                            st_nxt.ch[i].step = `FRAC_ONE;
                        end else begin
                            st_nxt.ch[i].ph   = dac_slew_pkg::PH_DOWN;
                            st_nxt.ch[i].step = down_step;
                        end
                    end else begin
                        st_nxt.ch[i].pos  = sum[20:0]; // R1
                        st_nxt.ch[i].step = st_r.ch[i].step + (st_r.ch[i].step >> `GROW_SHIFT); // R2
                    end
                end else begin
                    if (22'(st_r.ch[i].pos) <= 22'(lo_fx) + 22'(st_r.ch[i].step)) begin
                        // Clamp at the lower bound
                        st_nxt.ch[i].pos = lo_fx; // R19
                        if (wave == `WAVE_INV_SAW) begin
                            st_nxt.ch[i].pos  = hi_fx;
                            st_nxt.ch[i].step = down_step;
                        end else begin
                            st_nxt.ch[i].ph   = dac_slew_pkg::PH_UP;
                            st_nxt.ch[i].step = `FRAC_ONE;
                        end
                    end else begin
                        st_nxt.ch[i].pos  = st_r.ch[i].pos - st_r.ch[i].step; // R1
                        st_nxt.ch[i].step = st_r.ch[i].step - (st_r.ch[i].step >> `GROW_SHIFT); // R3
                    end
                end
            end
            if (st_nxt.ch[i].ph != dac_slew_pkg::PH_IDLE) begin
                st_nxt.ch[i].out = st_nxt.ch[i].pos[19:8] & RES_MASK;
            end
            st_nxt.ch[i].busy = (st_nxt.ch[i].ph != dac_slew_pkg::PH_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r        <= '0; // R9
            st_r.shared <= `SHARED_RST; // R16
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs taken straight from the state register
    assign rd_data                  = st_r.rdata;
    assign rd_valid                 = st_r.rvalid;
    assign out_code_first           = st_r.ch[0].out;
    assign out_code_second          = st_r.ch[1].out;
    assign busy_first               = st_r.ch[0].busy;
    assign busy_second              = st_r.ch[1].busy;
    assign window_hold_select       = st_r.shared[`F_WINDOW_HOLD];
    assign fault_log_row_select     = st_r.shared[`F_FAULT_ROW];
    assign int_ref_enable           = st_r.shared[`F_INT_REF]; // R14
    assign volt_out_shutdown_first  = st_r.shared[`F_VOLT_FIRST_HI:`F_VOLT_FIRST_LO];
    assign volt_out_shutdown_second = st_r.shared[`F_VOLT_SECOND_HI:`F_VOLT_SECOND_LO];
    assign curr_out_shutdown_first  = st_r.shared[`F_CURR_FIRST];
    assign curr_out_shutdown_second = st_r.shared[`F_CURR_SECOND];

    ////////////////////////////////////////////////////////////////////////
    // Checks on channel 0 and the register file
    logic ch0_tick;
    assign ch0_tick = st_r.run[0] && st_r.ch[0].busy && st_nxt.ch[0].timer == 20'h00000;

    property p_lock_holds;
        @(posedge clk) disable iff (!rst_n)
        (st_r.shared[`F_WRITE_LOCK] && wr_en && reg_addr == `ADDR_CODE_WORD_FIRST) |=> $stable(st_r.ch[0].code_word);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked write changed code word"); // R11

    property p_unlock_needs_key;
        @(posedge clk) disable iff (!rst_n)
        (st_r.shared[`F_WRITE_LOCK] && st_r.key != `UNLOCK_KEY && wr_en && reg_addr == `ADDR_SHARED_SETTINGS)
        |=> st_r.shared[`F_WRITE_LOCK];
    endproperty
    a_unlock_needs_key: assert property (p_unlock_needs_key) else $error("lock cleared without key"); // R21

    property p_code_low_zero;
        @(posedge clk) disable iff (!rst_n)
        (wr_en && !st_r.shared[`F_WRITE_LOCK] && reg_addr == `ADDR_CODE_WORD_FIRST)
        |=> st_r.ch[0].code_word[3:0] == `CODE_IGNORED && st_r.ch[0].code_word[15:4] == ($past(wr_data[15:4]) & RES_MASK);
    endproperty
    a_code_low_zero: assert property (p_code_low_zero) else $error("code word write wrong"); // R9

    property p_reset_shared;
        @(posedge clk) !rst_n |=> (volt_out_shutdown_first == 2'h3 && curr_out_shutdown_second && !int_ref_enable);
    endproperty
    a_reset_shared: assert property (p_reset_shared) else $error("shared word reset wrong"); // R16

    property p_row_follows;
        @(posedge clk) disable iff (!rst_n)
        (wr_en && !st_r.shared[`F_WRITE_LOCK] && reg_addr == `ADDR_SHARED_SETTINGS)
        |=> fault_log_row_select == $past(wr_data[13]) && window_hold_select == $past(wr_data[15]);
    endproperty
    a_row_follows: assert property (p_row_follows) else $error("shared fields not stored"); // R13

    property p_grow_up;
        @(posedge clk) disable iff (!rst_n)
        (ch0_tick && st_r.ch[0].ph == dac_slew_pkg::PH_UP && st_nxt.ch[0].ph == dac_slew_pkg::PH_UP
         && st_nxt.ch[0].pos != st_r.ch[0].pos
         && st_nxt.ch[0].pos != {1'b0, (lo_in[0] == 12'h000) ? 12'h001 : lo_in[0], 8'h00})
        |=> st_r.ch[0].step == $past(st_r.ch[0].step) + ($past(st_r.ch[0].step) >> 5);
    endproperty
    a_grow_up: assert property (p_grow_up) else $error("rising step growth wrong"); // R2

    property p_shrink_down;
        @(posedge clk) disable iff (!rst_n)
        (ch0_tick && st_r.ch[0].ph == dac_slew_pkg::PH_DOWN && st_nxt.ch[0].ph == dac_slew_pkg::PH_DOWN
         && st_nxt.ch[0].pos < st_r.ch[0].pos)
        |=> st_r.ch[0].step == $past(st_r.ch[0].step) - ($past(st_r.ch[0].step) >> 5);
    endproperty
    a_shrink_down: assert property (p_shrink_down) else $error("falling step shrink wrong"); // R3

    property p_in_bounds;
        @(posedge clk) disable iff (!rst_n)
        (busy_first && $stable(bound_high_first) && $stable(bound_low_first))
        |-> out_code_first <= (bound_high_first & RES_MASK);
    endproperty
    a_in_bounds: assert property (p_in_bounds) else $error("ramp overshoot"); // R19

    property p_start_one;
        @(posedge clk) disable iff (!rst_n)
        (st_r.run[0] && !busy_first && wave_valid(st_r.ch[0].wave_set[10:8]) && st_r.ch[0].wave_set[7]
         && st_r.ch[0].wave_set[10:8] != `WAVE_INV_SAW && bound_low_first == 12'h000)
        |=> out_code_first == (12'h001 & RES_MASK);
    endproperty
    a_start_one: assert property (p_start_one) else $error("zero low bound start wrong"); // R4

    property p_invalid_hold;
        @(posedge clk) disable iff (!rst_n)
        (st_r.run[0] && !wave_valid(st_r.ch[0].wave_set[10:8])) ##1 (st_r.run[0] && !wave_valid(st_r.ch[0].wave_set[10:8]))
        |-> $stable(out_code_first) && !busy_first;
    endproperty
    a_invalid_hold: assert property (p_invalid_hold) else $error("invalid wave moved output"); // R20

    c_unlock:   cover property (@(posedge clk) disable iff (!rst_n) $fell(st_r.shared[`F_WRITE_LOCK]));
    c_turn:     cover property (@(posedge clk) disable iff (!rst_n) busy_first && $changed(st_r.ch[0].ph));
    c_run_stop: cover property (@(posedge clk) disable iff (!rst_n) $fell(busy_second));
endmodule : dac_log_slew_and_common_config

`default_nettype wire

/* rtl/dac_slew_defines.svh */
// Constants for the waveform-settings and shared-configuration block.
// Assumes a 100 MHz clock and 8-bit register indices from the serial interface.
`ifndef DAC_SLEW_DEFINES_SVH
`define DAC_SLEW_DEFINES_SVH
// Register indices
`define ADDR_WAVE_SET_FIRST    8'h06
`define ADDR_WAVE_SET_SECOND   8'h18
`define ADDR_CODE_WORD_FIRST   8'h19
`define ADDR_CODE_WORD_SECOND  8'h1c
`define ADDR_SHARED_SETTINGS   8'h1f
`define ADDR_SHARED_ACTION     8'h20
`define ADDR_SHARED_RUN        8'h21
// Shared settings word fields
`define SHARED_RST             16'h0fff
`define F_WINDOW_HOLD          15
`define F_WRITE_LOCK           14
`define F_FAULT_ROW            13
`define F_INT_REF              12
`define F_VOLT_SECOND_HI       11
`define F_VOLT_SECOND_LO       10
`define F_CURR_SECOND          9
`define F_VOLT_FIRST_HI        2
`define F_VOLT_FIRST_LO        1
`define F_CURR_FIRST           0
// Shared action and run fields
`define F_KEY_HI               15
`define F_KEY_LO               12
`define UNLOCK_KEY             4'h5
`define F_RUN_SECOND           0
`define F_RUN_FIRST            12
// Waveform settings fields
`define F_WAVE_HI              10
`define F_WAVE_LO              8
`define F_LOG_SLEW             7
`define F_RISE_HI              6
`define F_RISE_LO              4
`define F_FALL_HI              3
`define F_FALL_LO              1
`define WAVE_TRIANGLE          3'h0
`define WAVE_SAW               3'h1
`define WAVE_INV_SAW           3'h2
`define WAVE_SINE              3'h4
`define WAVE_OFF               3'h7
// Code word layout
`define F_CODE_HI              15
`define F_CODE_LO              4
`define CODE_IGNORED           4'h0
// Ramp arithmetic: 8 fraction bits, growth of 1/32 per step
`define FRAC_ONE               21'h000100
`define GROW_SHIFT             5
// Step intervals in ns and the clock period in ns
`define CLK_NS                 10
`define STEP_NS_0              4000
`define STEP_NS_1              12000
`define STEP_NS_2              27040
`define STEP_NS_3              60720
`define STEP_NS_4              136720
`define STEP_NS_5              418640
`define STEP_NS_6              1282000
`define STEP_NS_7              5127920
`endif

/* rtl/dac_slew_pkg.sv */
// Types shared by the waveform-settings and shared-configuration block.
// Assumes the constants header is included by the design file.
package dac_slew_pkg;
    typedef enum logic [1:0] {PH_IDLE, PH_UP, PH_DOWN} ramp_phase_t;

    typedef struct packed {
        logic [15:0] wave_set;
        logic [15:0] code_word;
        ramp_phase_t ph;
        logic [20:0] pos;
        logic [20:0] step;
        logic [19:0] timer;
        logic [11:0] out;
        logic        busy;
    } chan_t;

    typedef struct packed {
        chan_t [1:0] ch;
        logic [15:0] shared;
        logic [3:0]  key;
        logic [1:0]  run;
        logic [15:0] rdata;
        logic        rvalid;
    } state_t;
endpackage : dac_slew_pkg

/* test/dac_log_slew_and_common_config_tb.sv */
// Self-checking bench for the settings bank and log-slew ramp.
// Assumes host_model on the register port; step table shortened.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; $display("unexpected %0t: %h not %h", $time, a, e); end end
module dac_log_slew_and_common_config_tb;
    logic        clk, rst_n, wr_en, rd_en, rd_valid, busy_first, busy_second;
    logic        window_hold_select, fault_log_row_select, int_ref_enable;
    logic        curr_out_shutdown_first, curr_out_shutdown_second;
    logic [1:0]  volt_out_shutdown_first, volt_out_shutdown_second;
    logic [7:0]  reg_addr;
    logic [15:0] wr_data, rd_data, d;
    logic [11:0] bound_low_first, bound_high_first, bound_low_second, bound_high_second;
    logic [11:0] out_code_first, out_code_second, prev = 12'h000;
    logic        v, up;
    int          fails, checks_done, cyc, last, rgap, fgap;
    logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3, 3'h5, 3'h6};

    dac_log_slew_and_common_config #(.STEP_CYC('{4, 5, 6, 7, 8, 9, 10, 11})) uut (
        .clk, .rst_n, .wr_en, .rd_en, .reg_addr, .wr_data, .bound_low_first,
        .bound_high_first, .bound_low_second, .bound_high_second, .rd_data, .rd_valid,
        .out_code_first, .out_code_second, .busy_first, .busy_second, .window_hold_select,
        .fault_log_row_select, .int_ref_enable, .volt_out_shutdown_first,
        .volt_out_shutdown_second, .curr_out_shutdown_first, .curr_out_shutdown_second);
    host_model h (.clk, .rd_valid, .rd_data, .wr_en, .rd_en, .reg_addr, .wr_data);

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Step gaps of the first channel, only between same-direction steps
    always @(negedge clk) begin
        cyc++;
        `CHK(busy_first === 1'b1 && out_code_first > bound_high_first, 1'b0)
        if (out_code_first != prev) begin
            if ((out_code_first > prev) == up && up)
                rgap = cyc - last;
            else if ((out_code_first > prev) == up)
                fgap = cyc - last;
            up   = out_code_first > prev;
            last = cyc;
            prev = out_code_first;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {bound_low_first, bound_high_first} = {12'h000, 12'h008};
        {bound_low_second, bound_high_second} = {12'h000, 12'h008};
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        h.rd(8'h1f, d, v);
        `CHK({v, d}, 17'h1_0fff)
        `CHK({volt_out_shutdown_first, volt_out_shutdown_second, curr_out_shutdown_first,
              curr_out_shutdown_second, window_hold_select, fault_log_row_select,
              int_ref_enable}, 9'h1f8)
        h.rd(8'h19, d, v);
        `CHK(d, 16'h0000)
        h.wr(8'h19, 16'habcf);
        h.rd(8'h19, d, v);
        `CHK(d, 16'habc0)
        h.wr(8'h1f, 16'h1fff);
        `CHK(int_ref_enable, 1'b1)
        h.wr(8'h1f, 16'ha402);
        h.rd(8'h1f, d, v);
        `CHK({window_hold_select, fault_log_row_select, int_ref_enable, volt_out_shutdown_second,
              volt_out_shutdown_first, curr_out_shutdown_second, curr_out_shutdown_first},
             9'b110_01_01_00)
        h.rd(8'h07, d, v);
        `CHK({v, d}, 17'h1_0000)
        $display("test registers done");
        // Locked: code write and keyless unlock both ignored
        h.wr(8'h1f, 16'h4000);
        h.wr(8'h19, 16'h1230);
        h.wr(8'h1f, 16'h0000);
        h.rd(8'h19, d, v);
        `CHK(d, 16'habc0)
        h.rd(8'h1f, d, v);
        `CHK(d, 16'h4000)
        h.unlock(16'h0000);
        h.rd(8'h1f, d, v);
        `CHK(d, 16'h0000)
        $display("test lock done");
        // Valid waves start a ramp, triangle from code one; the rest hold the code word
        foreach (codes[i]) begin
            h.wr(8'h06, {5'h00, codes[i], 8'h80});
            h.wr(8'h21, 16'h1001);
            repeat (3) @(negedge clk);
            `CHK(busy_first, i < 4)
            if (i == 0)
                `CHK(out_code_first, 12'h001)
            if (i > 3)
                `CHK(out_code_first, 12'habc)
            h.wr(8'h21, 16'h0000);
        end
        $display("test wave codes done");
        // Rise and fall intervals for every code
        for (int k = 0; k < 8; k++) begin
            h.wr(8'h06, 16'(8'h80 | k << 4 | (7 - k) << 1));
            h.wr(8'h21, 16'h1000);
            h.rd(8'h21, d, v);
            `CHK(d, 16'h1000)
            repeat (300) @(negedge clk);
            `CHK(rgap, 4 + k)
            `CHK(fgap, 11 - k)
            h.wr(8'h21, 16'h0000);
        end
        $display("test intervals done");
        // Second channel: code word, run on bit 0, settings readback
        h.wr(8'h1c, 16'h5a5f);
        h.rd(8'h1c, d, v);
        `CHK({d, out_code_second}, 28'h5a505a5)
        h.wr(8'h18, 16'h0080);
        h.wr(8'h21, 16'h0001);
        h.rd(8'h21, d, v);
        `CHK(d, 16'h0001)
        `CHK({busy_second, busy_first, out_code_second}, 14'h2001)
        h.rd(8'h18, d, v);
        `CHK(d, 16'h0080)
        $display("test second channel done");
        // Reset in mid-run clears the code word, restores the shared word to 0fff and stops the ramp
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        h.rd(8'h1c, d, v);
        `CHK({v, d, busy_second, out_code_second}, 30'h20000000)
        h.rd(8'h1f, d, v);
        `CHK(d, 16'h0fff)
        $display("test reset done");
        stop_test();
    end
endmodule : dac_log_slew_and_common_config_tb
`default_nettype wire

/* test/host_model.sv */
// Host side of the register port: strobes, index and data.
// Assumes the device samples on rising clk and answers reads a cycle later.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clk,
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data,
    output logic             wr_en,
    output logic             rd_en,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] wr_data
);
    initial begin
        wr_en    = 1'b0;
        rd_en    = 1'b0;
        reg_addr = 8'h00;
        wr_data  = 16'h0000;
    end
    // One write, strobe held across exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        wr_data  = d;
        wr_en    = 1'b1;
        @(negedge clk);
        wr_en    = 1'b0;
    endtask : wr
    // Answer only stands one cycle, so it is taken at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge clk);
        reg_addr = a;
        rd_en    = 1'b1;
        @(negedge clk);
        rd_en    = 1'b0;
        v        = rd_valid;
        d        = rd_data;
    endtask : rd
    // Key must land before the lock bit is cleared
    task automatic unlock(input logic [15:0] cfg);
        wr(8'h20, 16'h5000);
        wr(8'h1f, cfg);
    endtask : unlock
endmodule : host_model
`default_nettype wire
